// file: rtl/amc_pkg.sv
// package of constants and types for the mode command sequencer
package amc_pkg;
    localparam int CMD_W = 16;
    localparam logic [15:0] CMD_HOLD = 16'h0000;
    localparam logic [15:0] CMD_LIGHT = 16'h8200;
    localparam logic [15:0] CMD_DEEP = 16'h8300;
    localparam logic [15:0] CMD_RST = 16'h8500;
    localparam logic [15:0] CMD_SCAN = 16'hA000;
    localparam logic [15:0] CMD_FIX0 = 16'hC000;
    localparam logic [15:0] CMD_FIX_STEP = 16'h0400;
    localparam logic [15:0] CMD_AUX = 16'hE000;
    localparam logic [4:0] CNT_CMD = 5'h10;
    localparam logic [5:0] CNT_FULL = 6'h20;
    localparam logic [3:0] CH_AUX = 4'h8;
    localparam logic [7:0] SEQ_RST = 8'hFF;
    localparam int CLK_MHZ = 200;
    localparam int WAKE_US = 20;
    localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
    localparam int DEEP_MS = 15;
    localparam int DEEP_CYC = DEEP_MS * 1000 * CLK_MHZ;

    typedef enum {
        ST_IDLE, ST_INVALID, ST_LIGHT, ST_DEEP, ST_SCAN, ST_FIXED, ST_RSTMODE
    } amc_mode_t;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic sdi;
    } amc_link_t;

    typedef struct packed {
        logic [3:0] chan;
        logic convert;
        logic data_valid;
        logic ref_on;
        logic core_on;
        logic ready;
    } amc_stat_t;
endpackage : amc_pkg

// file: rtl/amc_sequencer.sv
// operating-mode command sequencer of a multichannel converter
`timescale 1ns/10ps
// Function
// - all-zero command keeps last selected mode, from invalid state returns idle
// - zero frame during register access returns idle
// - frame starts at select fall, sixteen bits
// - act only after sixteenth falling clock edge
// - early select rise enters invalid state
// - invalid state gives invalid read data
// - 8200h enters light sleep at rise
// - light sleep wakes within twenty microseconds
// - light sleep exit keeps program registers
// - light sleep waits for conversion command
// - scan or fixed command exits light sleep
// - 8300h enters deep sleep at rise
// - pin wake resets registers, command keeps
// - deep sleep waits for conversion command
// - valid command leaves deep sleep at rise
// - A000h selects scan with restart
// - scan enabled channels ascending and wrap
// - zero frames keep automatic scan going
// - scan command again restarts from lowest
// - fixed codes C000h step 0400h, E000h auxiliary
// - 8500h restores defaults, stops conversions
module amc_sequencer #(
    parameter int WAKE_CYCLES = amc_pkg::WAKE_CYC,
    parameter int DEEP_CYCLES = amc_pkg::DEEP_CYC
) (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire amc_pkg::amc_link_t LINK,
    input wire logic [7:0] SEQ_ENABLE,
    input wire logic HW_POWER_DOWN,
    input wire logic REG_ACCESS,
    output amc_pkg::amc_stat_t STAT,
    output logic REG_DEFAULTS,
    output logic [15:0] CMD_WORD
);
    // ----------------------------------------
    // link synchronisers
    // ----------------------------------------
    logic [2:0] s1_r, s2_r, s3_r;
    logic hpd1_r, hpd2_r, hpd3_r;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_r <= 3'h7;
            s2_r <= 3'h7;
            s3_r <= 3'h7;
            hpd1_r <= 1'h0;
            hpd2_r <= 1'h0;
            hpd3_r <= 1'h0;
        end else if (CE) begin
            s1_r <= {LINK.cs_n, LINK.sclk, LINK.sdi};
            s2_r <= s1_r;
            s3_r <= s2_r;
            hpd1_r <= HW_POWER_DOWN;
            hpd2_r <= hpd1_r;
            hpd3_r <= hpd2_r;
        end
    end
    logic cs_fall, cs_rise, sclk_fall, cs_low, sdi_s;
    assign cs_low = !s2_r[2];
    assign cs_fall = s3_r[2] && !s2_r[2];
    assign cs_rise = !s3_r[2] && s2_r[2];
    assign sclk_fall = s3_r[1] && !s2_r[1] && cs_low;
    assign sdi_s = s2_r[0];

    // ----------------------------------------
    // command shift and edge count
    // ----------------------------------------
    logic [15:0] sh_r;
    logic [5:0] cnt_r;
    logic [15:0] cmd;
    logic cmd_done, full_frame;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            sh_r <= 16'h0000;
            cnt_r <= 6'h00;
        end else if (CE) begin
            if (cs_fall) begin
                cnt_r <= 6'h00;
                sh_r <= 16'h0000;
            end else if (sclk_fall && cnt_r != 6'h3F) begin
                cnt_r <= cnt_r + 6'h01;
                if (cnt_r < {1'b0, amc_pkg::CNT_CMD}) begin
                    sh_r <= {sh_r[14:0], sdi_s};
                end
            end
        end
    end
    assign cmd = sh_r;
    assign cmd_done = cnt_r >= {1'b0, amc_pkg::CNT_CMD};
    assign full_frame = cnt_r >= amc_pkg::CNT_FULL;

    // decode of fixed channel codes
    logic is_fix;
    logic [3:0] fix_ch;
    always_comb begin
        is_fix = 1'b0;
        fix_ch = 4'h0;
        for (int i = 0; i < 8; i++) begin
            if (cmd == 16'(amc_pkg::CMD_FIX0 + 16'(i) * amc_pkg::CMD_FIX_STEP)) begin
                is_fix = 1'b1;
                fix_ch = 4'(i);
            end
        end
        if (cmd == amc_pkg::CMD_AUX) begin
            is_fix = 1'b1;
            fix_ch = amc_pkg::CH_AUX;
        end
    end

    // ----------------------------------------
    // mode machine
    // ----------------------------------------
    amc_pkg::amc_mode_t mode_r;
    logic [3:0] chan_r;
    logic seq_restart, seq_step, rst_pulse_r, racc_r;
    assign seq_restart = CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_SCAN;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            mode_r <= amc_pkg::ST_IDLE;
            rst_pulse_r <= 1'b1;
        end else if (CE) begin
            rst_pulse_r <= 1'b0;
            if (hpd2_r) begin
                mode_r <= amc_pkg::ST_DEEP;
            end else if (hpd3_r) begin
                rst_pulse_r <= 1'b1;
                mode_r <= amc_pkg::ST_IDLE;
            end else if (cs_rise && !cmd_done) begin
                mode_r <= amc_pkg::ST_INVALID;
            end else if (cs_rise) begin
                if (cmd == amc_pkg::CMD_HOLD) begin
                    if (racc_r || mode_r == amc_pkg::ST_INVALID) begin
                        mode_r <= amc_pkg::ST_IDLE;
                    end
                end else if (cmd == amc_pkg::CMD_LIGHT) begin
                    mode_r <= amc_pkg::ST_LIGHT;
                end else if (cmd == amc_pkg::CMD_DEEP) begin
                    mode_r <= amc_pkg::ST_DEEP;
                end else if (cmd == amc_pkg::CMD_RST) begin
                    mode_r <= amc_pkg::ST_RSTMODE;
                    rst_pulse_r <= 1'b1;
                end else if (cmd == amc_pkg::CMD_SCAN) begin
                    mode_r <= amc_pkg::ST_SCAN;
                end else if (is_fix) begin
                    mode_r <= amc_pkg::ST_FIXED;
                end else if (mode_r == amc_pkg::ST_DEEP) begin
                    mode_r <= amc_pkg::ST_DEEP;
                end
            end
        end
    end

    // register access flag sampled from REG_ACCESS at every select fall
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            racc_r <= 1'b0;
        end else if (CE) begin
            if (cs_fall) begin
                racc_r <= REG_ACCESS;
            end
        end
    end

    // ----------------------------------------
    // channel selection
    // ----------------------------------------
    // next enabled channel above current, else lowest enabled
    logic [3:0] low_ch, next_ch;
    always_comb begin
        low_ch = 4'h0;
        next_ch = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (SEQ_ENABLE[i]) begin
                low_ch = 4'(i);
            end
        end
        next_ch = low_ch;
        for (int i = 7; i >= 0; i--) begin
            if (SEQ_ENABLE[i] && 4'(i) > chan_r) begin
                next_ch = 4'(i);
            end
        end
    end
    logic first_r;
    assign seq_step = CE && cs_fall && mode_r == amc_pkg::ST_SCAN && !first_r;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            chan_r <= 4'h0;
            first_r <= 1'b0;
        end else if (CE) begin
            if (cs_rise && cmd_done && is_fix) begin
                chan_r <= fix_ch;
            end else if (seq_restart) begin
                chan_r <= low_ch;
                first_r <= 1'b1;
            end else if (cs_fall && mode_r == amc_pkg::ST_SCAN) begin
                if (first_r) begin
                    first_r <= 1'b0;
                end else begin
                    chan_r <= next_ch;
                end
            end
        end
    end

    // ----------------------------------------
    // wake timers
    // ----------------------------------------
    logic [31:0] wake_r;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wake_r <= 32'h0000_0000;
        end else if (CE) begin
            if (mode_r == amc_pkg::ST_LIGHT) begin
                wake_r <= 32'(WAKE_CYCLES);
            end else if (mode_r == amc_pkg::ST_DEEP) begin
                wake_r <= 32'(DEEP_CYCLES);
            end else if (wake_r != 32'h0000_0000) begin
                wake_r <= wake_r - 32'h0000_0001;
            end
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    logic conv;
    assign conv = mode_r == amc_pkg::ST_SCAN || mode_r == amc_pkg::ST_FIXED;
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            STAT <= '0;
            REG_DEFAULTS <= 1'b0;
            CMD_WORD <= 16'h0000;
        end else if (CE) begin
            STAT.chan <= chan_r;
            STAT.convert <= conv;
            // sleeping or aborted states give no valid data
            STAT.data_valid <= conv && cmd_done && wake_r == 32'h0000_0000;
            STAT.ref_on <= mode_r != amc_pkg::ST_DEEP;
            STAT.core_on <= conv;
            STAT.ready <= wake_r == 32'h0000_0000;
            REG_DEFAULTS <= rst_pulse_r;
            if (cs_rise && cmd_done) begin
                CMD_WORD <= cmd;
            end
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_ABORT: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && !cmd_done && !hpd2_r && !hpd3_r |=> mode_r == amc_pkg::ST_INVALID)
        else $error("aborted frame did not enter invalid state");
    AST_LIGHT: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_LIGHT && !hpd2_r && !hpd3_r
        |=> mode_r == amc_pkg::ST_LIGHT)
        else $error("light sleep not entered");
    AST_DEEP: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_DEEP && !hpd2_r && !hpd3_r
        |=> mode_r == amc_pkg::ST_DEEP ##1 !STAT.ref_on || !CE)
        else $error("deep sleep not entered");
    AST_HOLD: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_HOLD && !racc_r && !hpd2_r
        && !hpd3_r && mode_r != amc_pkg::ST_INVALID |=> $stable(mode_r))
        else $error("hold frame changed mode");
    AST_REGIDLE: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_HOLD && racc_r && !hpd2_r
        && !hpd3_r |=> mode_r == amc_pkg::ST_IDLE)
        else $error("zero frame in register access did not idle");
    AST_RESTART: assert property (@(posedge CLK) disable iff (!RESET_N)
        seq_restart |=> chan_r == $past(low_ch))
        else $error("scan did not restart at lowest channel");
    AST_STEP: assert property (@(posedge CLK) disable iff (!RESET_N)
        seq_step && !(cs_rise) |=> SEQ_ENABLE[chan_r[2:0]] || SEQ_ENABLE == 8'h00)
        else $error("scan picked disabled channel");
    AST_RSTCMD: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_rise && cmd_done && cmd == amc_pkg::CMD_RST && !hpd2_r && !hpd3_r
        |=> !conv)
        else $error("reset command left conversions on");
    AST_NOACT: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && cs_fall |=> !cmd_done)
        else $error("command counted done at frame start");
    AST_SLEEPDATA: assert property (@(posedge CLK) disable iff (!RESET_N)
        CE && full_frame && (mode_r == amc_pkg::ST_LIGHT || mode_r == amc_pkg::ST_DEEP)
        |=> !STAT.data_valid)
        else $error("sleep frame gave valid data");
    COV_SCAN: cover property (@(posedge CLK) seq_restart);
    COV_ABORT: cover property (@(posedge CLK) mode_r == amc_pkg::ST_INVALID);
    COV_LWAKE: cover property (@(posedge CLK)
        mode_r == amc_pkg::ST_LIGHT ##1 mode_r == amc_pkg::ST_FIXED);
    COV_DWAKE: cover property (@(posedge CLK)
        mode_r == amc_pkg::ST_DEEP ##1 mode_r == amc_pkg::ST_FIXED);
endmodule : amc_sequencer

// file: testbench/amc_host.sv
// host-side serial link driver for the mode command sequencer
`timescale 1ns/10ps
module amc_host (
    input wire logic clk,
    output amc_pkg::amc_link_t link
);
    initial begin
        link = '{cs_n: 1'b1, sclk: 1'b1, sdi: 1'b0};
    end
    // ----------------------------------------
    // frame: n bits msb first, fewer than 16 aborts
    // ----------------------------------------
    task automatic send(input logic [31:0] w, input int n, input int gap);
        int i;
        @(posedge clk) link.cs_n <= 1'b0;
        repeat (4) @(posedge clk);
        // the link clock keeps its own 64 ns period, unrelated to clk
        for (i = 0; i < n; i++) begin
            link.sdi <= w[31 - i];
            #16 link.sclk <= 1'b0;
            #32 link.sclk <= 1'b1;
            #16;
        end
        // select stays low until the last falling edge has been seen
        repeat (4) @(posedge clk);
        link.cs_n <= 1'b1;
        // released data line must not look like the last bit
        link.sdi <= ~link.sdi;
        repeat (12 + gap) @(posedge clk);
    endtask : send
endmodule : amc_host

// file: testbench/tb.sv
// self-checking bench for the mode command sequencer
`timescale 1ns/10ps
module tb;
    localparam int WAKE = 8;
    logic CLK, RESET_N, CE, HW_POWER_DOWN, REG_ACCESS;
    logic [7:0] SEQ_ENABLE, lfsr;
    logic [15:0] CMD_WORD;
    logic REG_DEFAULTS;
    amc_pkg::amc_link_t LINK;
    amc_pkg::amc_stat_t STAT;
    int fails, samples_checked, cyc, pulses, p0, i, k;
    int q[$];
    amc_sequencer #(.WAKE_CYCLES(WAKE), .DEEP_CYCLES(16)) amc_sequencer_i (.CLK(CLK),
        .RESET_N(RESET_N), .CE(CE), .LINK(LINK), .SEQ_ENABLE(SEQ_ENABLE),
        .HW_POWER_DOWN(HW_POWER_DOWN), .REG_ACCESS(REG_ACCESS), .STAT(STAT),
        .REG_DEFAULTS(REG_DEFAULTS), .CMD_WORD(CMD_WORD));
    amc_host amc_host_i (.clk(CLK), .link(LINK));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic chk_mode(input int ch, input logic conv);
        chk({12'h000, STAT.chan}, 16'(ch));
        chk({15'h0000, STAT.convert}, {15'h0000, conv});
    endtask : chk_mode
    task automatic frame(input logic [15:0] cmd);
        amc_host_i.send({cmd, lfsr, ~lfsr}, 32, 0);
        lfsr = lfsr_next(lfsr);
    endtask : frame
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // ----------------------------------------
    // clock, watchdog, pulse counter
    // ----------------------------------------
    initial begin
        CLK = 1'b0;
        forever #2.5 CLK = ~CLK;
    end
    always @(posedge CLK) begin
        cyc++;
        if (REG_DEFAULTS === 1'b1) pulses++;
        if (cyc == 30000) begin
            fails++;
            print_verdict();
        end
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        RESET_N = 1'b0;
        CE = 1'b1;
        HW_POWER_DOWN = 1'b0;
        REG_ACCESS = 1'b0;
        lfsr = 8'h1F;
        SEQ_ENABLE = 8'h00;
        repeat (16) @(posedge CLK);
        RESET_N <= 1'b1;
        SEQ_ENABLE <= lfsr | 8'h22;
        @(posedge CLK);
        for (i = 0; i < 8; i++) if (SEQ_ENABLE[i]) q.push_back(i);
        frame(amc_pkg::CMD_SCAN);
        chk(CMD_WORD, amc_pkg::CMD_SCAN);
        chk_mode(q[0], 1'b1);
        chk({15'h0000, STAT.data_valid}, 16'h0001);
        for (k = 1; k <= q.size() + 1; k++) begin
            frame(amc_pkg::CMD_HOLD);
            // the frame after a restart converts the lowest channel itself
            chk_mode(q[(k - 1) % q.size()], 1'b1);
        end
        frame(amc_pkg::CMD_SCAN);
        chk_mode(q[0], 1'b1);
        for (i = 0; i < 9; i++) begin
            frame(i < 8 ? amc_pkg::CMD_FIX0 + 16'(i) * amc_pkg::CMD_FIX_STEP : amc_pkg::CMD_AUX);
            chk_mode(i, 1'b1);
        end
        frame(amc_pkg::CMD_HOLD);
        chk_mode(amc_pkg::CH_AUX, 1'b1);
        amc_host_i.send({amc_pkg::CMD_FIX0, 16'h0000}, 8, 0);
        chk({15'h0000, STAT.data_valid}, 16'h0000);
        chk({12'h000, STAT.chan}, {12'h000, amc_pkg::CH_AUX});
        chk(CMD_WORD, amc_pkg::CMD_HOLD);
        p0 = pulses;
        frame(amc_pkg::CMD_LIGHT);
        chk({15'h0000, STAT.convert}, 16'h0000);
        chk({15'h0000, STAT.ref_on}, 16'h0001);
        frame(amc_pkg::CMD_HOLD);
        chk({14'h0000, STAT.data_valid, STAT.ready}, 16'h0000);
        amc_host_i.send({16'hC400, 16'h0000}, 16, 2 * WAKE);
        for (i = 0; i < 20 * WAKE && STAT.ready !== 1'b1; i++) @(posedge CLK);
        chk({15'h0000, STAT.ready}, 16'h0001);
        chk_mode(1, 1'b1);
        frame(amc_pkg::CMD_DEEP);
        chk({15'h0000, STAT.ref_on}, 16'h0000);
        frame(amc_pkg::CMD_HOLD);
        chk({13'h0000, STAT.ref_on, STAT.convert, STAT.core_on}, 16'h0000);
        amc_host_i.send({amc_pkg::CMD_FIX0, 16'h0000}, 16, 32);
        chk_mode(0, 1'b1);
        chk(16'(pulses - p0), 16'h0000);
        frame(amc_pkg::CMD_RST);
        chk(16'(pulses - p0), 16'h0001);
        chk({15'h0000, STAT.convert}, 16'h0000);
        frame(amc_pkg::CMD_SCAN);
        REG_ACCESS <= 1'b1;
        frame(amc_pkg::CMD_HOLD);
        REG_ACCESS <= 1'b0;
        chk({15'h0000, STAT.convert}, 16'h0000);
        chk(16'(pulses - p0), 16'h0001);
        HW_POWER_DOWN <= 1'b1;
        repeat (10) @(posedge CLK);
        chk({15'h0000, STAT.ref_on}, 16'h0000);
        HW_POWER_DOWN <= 1'b0;
        repeat (10) @(posedge CLK);
        chk(16'(pulses - p0), 16'h0002);
        print_verdict();
    end
endmodule : tb
